// file: csa_cfg.svh
// Offsets, field positions, reset values and timing counts of the core status block
`ifndef CSA_CFG_SVH
`define CSA_CFG_SVH
// Special-function addresses
`define CSA_ADR_STACK 8'h81
`define CSA_ADR_PTR_LO 8'h82
`define CSA_ADR_PTR_HI 8'h83
`define CSA_ADR_POWER 8'h87
`define CSA_ADR_AUX 8'h8e
`define CSA_ADR_AUX2 8'ha2
`define CSA_ADR_STATUS 8'hd0
`define CSA_ADR_WORK 8'he0
`define CSA_ADR_MULDIV 8'hf0
`define CSA_ADR_VERSION 8'hfb
// Status word fields
`define CSA_ST_CARRY 7
`define CSA_ST_AUX_CARRY 6
`define CSA_ST_USER0 5
`define CSA_ST_BANK_HI 4
`define CSA_ST_BANK_LO 3
`define CSA_ST_EXCESS 2
`define CSA_ST_USER1 1
`define CSA_ST_ODD 0
// Auxiliary control fields
`define CSA_AX_RSVD 7
`define CSA_AX_WIDE 6
`define CSA_AX_STRETCH 5
`define CSA_AX_PHS 4
`define CSA_AX_SIZE_HI 3
`define CSA_AX_SIZE_LO 2
`define CSA_AX_OFFCHIP 1
`define CSA_AX_QUIET 0
// Second auxiliary fields
`define CSA_AX2_FLAG 3
`define CSA_AX2_PSEL 0
// Reset values
`define CSA_RST_STATUS 8'h00
`define CSA_RST_AUX 7'h0d
`define CSA_RST_STACK 8'h07
// Timing in CPU clock periods
`define CSA_STROBE_SHORT 3
`define CSA_STROBE_LONG 15
`define CSA_ALE_DIV 3
// Expanded RAM boundaries per size code
`define CSA_ERAM_LIM0 16'h0100
`define CSA_ERAM_LIM1 16'h0200
`define CSA_ERAM_LIM2 16'h0400
`define CSA_ERAM_LIM3 16'h0800
`endif

// file: csa_pkg.sv
// Types shared by the core status block
package csa_pkg;
   typedef enum logic [2:0] {
      CSA_IDLE = 3'b001,
      CSA_ADDR = 3'b010,
      CSA_STRB = 3'b100
   } csa_move_state_t;
endpackage

// file: csa_core_regs.sv
// Core status word, auxiliary controls and external move sequencing
`include "csa_cfg.svh"
module csa_core_regs #(
   parameter logic [7:0] VERSION = 8'h5a  // Arbitrary value
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Special-function access
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // ALU results
   input wire logic alu_carry_we_i,
   input wire logic alu_carry_i,
   input wire logic alu_aux_carry_we_i,
   input wire logic alu_aux_carry_i,
   input wire logic alu_excess_we_i,
   input wire logic alu_excess_i,
   input wire logic work_we_i,
   input wire logic [7:0] work_wdata_i,
   // Core view
   output logic [7:0] program_status_o,
   output logic [7:0] working_register_o,
   output logic [1:0] register_bank_select_o,
   output logic [15:0] data_pointer_o,
   // External move request
   input wire logic xmov_start_i,
   input wire logic xmov_via_ptr_i,
   input wire logic xmov_write_i,
   input wire logic [7:0] xmov_ri_addr_i,
   input wire logic [7:0] port_latch_i,
   output logic xmov_busy_o,
   // External bus and expanded RAM
   output logic ext_rd_b_o,
   output logic ext_wr_b_o,
   output logic ale_o,
   output logic [7:0] high_addr_o,
   output logic [7:0] low_addr_o,
   output logic wide_access_o,
   output logic eram_access_o,
   output logic [10:0] eram_addr_o
);
   ////////////////////////////////////////////////////////////////////////////
   logic rst_s1_q, rst_b_q;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_b_q <= rst_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] stack_q, power_q, work_q, muldiv_q;
   logic [7:0] ptr_lo_q [2];
   logic [7:0] ptr_hi_q [2];
   logic [6:0] aux_q;
   logic psel_q, aux2_flag_q;
   logic [7:1] st_q;
   logic wr_st, wr_aux;
   assign wr_st = sfr_wr_i && (sfr_addr_i == `CSA_ADR_STATUS);
   assign wr_aux = sfr_wr_i && (sfr_addr_i == `CSA_ADR_AUX);

   // Odd-ones flag from the live register, so a read never lags a write
   assign program_status_o = {st_q, ^work_q};
   assign working_register_o = work_q;
   assign register_bank_select_o = st_q[`CSA_ST_BANK_HI:`CSA_ST_BANK_LO];
   assign data_pointer_o = {ptr_hi_q[psel_q], ptr_lo_q[psel_q]};

   // ALU updates land after the software write so a same-cycle flag event wins
   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         st_q <= 7'(`CSA_RST_STATUS >> 1);
      end else begin
         if (wr_st) begin
            st_q <= sfr_wdata_i[7:1];
         end
         if (alu_carry_we_i) begin
            st_q[`CSA_ST_CARRY] <= alu_carry_i;
         end
         if (alu_aux_carry_we_i) begin
            st_q[`CSA_ST_AUX_CARRY] <= alu_aux_carry_i;
         end
         if (alu_excess_we_i) begin
            st_q[`CSA_ST_EXCESS] <= alu_excess_i;
         end
      end
   end

   // Reserved bit is not stored; software must keep it zero
   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         aux_q <= `CSA_RST_AUX;
      end else if (wr_aux) begin
         aux_q <= sfr_wdata_i[6:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         work_q <= 8'h00;
      end else if (work_we_i) begin
         work_q <= work_wdata_i;
      end else if (sfr_wr_i && sfr_addr_i == `CSA_ADR_WORK) begin
         work_q <= sfr_wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         stack_q <= `CSA_RST_STACK;
         power_q <= 8'h00;
         muldiv_q <= 8'h00;
         psel_q <= 1'b0;
         aux2_flag_q <= 1'b0;
         ptr_lo_q[0] <= 8'h00;
         ptr_lo_q[1] <= 8'h00;
         ptr_hi_q[0] <= 8'h00;
         ptr_hi_q[1] <= 8'h00;
      end else if (sfr_wr_i) begin
         if (sfr_addr_i == `CSA_ADR_STACK) begin
            stack_q <= sfr_wdata_i;
         end else if (sfr_addr_i == `CSA_ADR_POWER) begin
            power_q <= sfr_wdata_i;
         end else if (sfr_addr_i == `CSA_ADR_MULDIV) begin
            muldiv_q <= sfr_wdata_i;
         end else if (sfr_addr_i == `CSA_ADR_AUX2) begin
            psel_q <= sfr_wdata_i[`CSA_AX2_PSEL];
            aux2_flag_q <= sfr_wdata_i[`CSA_AX2_FLAG];
         end else if (sfr_addr_i == `CSA_ADR_PTR_LO) begin
            ptr_lo_q[psel_q] <= sfr_wdata_i;
         end else if (sfr_addr_i == `CSA_ADR_PTR_HI) begin
            ptr_hi_q[psel_q] <= sfr_wdata_i;
         end
      end
   end

   // Read data is registered: valid the cycle after the read strobe
   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         if (sfr_addr_i == `CSA_ADR_STATUS) begin
            sfr_rdata_o <= program_status_o;
         end else if (sfr_addr_i == `CSA_ADR_AUX) begin
            sfr_rdata_o <= {1'b0, aux_q};
         end else if (sfr_addr_i == `CSA_ADR_WORK) begin
            sfr_rdata_o <= work_q;
         end else if (sfr_addr_i == `CSA_ADR_STACK) begin
            sfr_rdata_o <= stack_q;
         end else if (sfr_addr_i == `CSA_ADR_PTR_LO) begin
            sfr_rdata_o <= ptr_lo_q[psel_q];
         end else if (sfr_addr_i == `CSA_ADR_PTR_HI) begin
            sfr_rdata_o <= ptr_hi_q[psel_q];
         end else if (sfr_addr_i == `CSA_ADR_POWER) begin
            sfr_rdata_o <= power_q;
         end else if (sfr_addr_i == `CSA_ADR_AUX2) begin
            sfr_rdata_o <= {4'h0, aux2_flag_q, 2'b00, psel_q};
         end else if (sfr_addr_i == `CSA_ADR_MULDIV) begin
            sfr_rdata_o <= muldiv_q;
         end else if (sfr_addr_i == `CSA_ADR_VERSION) begin
            sfr_rdata_o <= VERSION;
         end else begin
            sfr_rdata_o <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   csa_pkg::csa_move_state_t state_q;
   logic [3:0] cnt_q;
   logic [1:0] div_q;
   logic wr_q, str_q, wide_q, eram_q, accept, eram_hit;
   logic [15:0] limit;
   logic [10:0] eram_addr_q;
   logic [7:0] hi_q, lo_q;

   always_comb begin
      case (aux_q[`CSA_AX_SIZE_HI:`CSA_AX_SIZE_LO])
         2'b00: limit = `CSA_ERAM_LIM0;
         2'b01: limit = `CSA_ERAM_LIM1;
         2'b10: limit = `CSA_ERAM_LIM2;
         default: limit = `CSA_ERAM_LIM3;
      endcase
   end
   // Largest boundary is 0800h, so pointer moves above it always go off chip
   assign eram_hit = !aux_q[`CSA_AX_OFFCHIP] &&
      (!xmov_via_ptr_i || data_pointer_o < limit);
   assign accept = xmov_start_i && (state_q == csa_pkg::CSA_IDLE);
   assign xmov_busy_o = (state_q != csa_pkg::CSA_IDLE);

   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         state_q <= csa_pkg::CSA_IDLE;
         cnt_q <= 4'h0;
      end else begin
         case (state_q)
            csa_pkg::CSA_IDLE: begin
               if (accept && !eram_hit) begin
                  state_q <= csa_pkg::CSA_ADDR;
               end
            end
            csa_pkg::CSA_ADDR: begin
               state_q <= csa_pkg::CSA_STRB;
               cnt_q <= str_q ? 4'(`CSA_STROBE_LONG - 1) : 4'(`CSA_STROBE_SHORT - 1);
            end
            csa_pkg::CSA_STRB: begin
               if (cnt_q == 4'h0) begin
                  state_q <= csa_pkg::CSA_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: state_q <= csa_pkg::CSA_IDLE;
         endcase
      end
   end

   // Mode bits are captured per move so a mid-cycle write cannot tear a strobe
   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         wr_q <= 1'b0;
         str_q <= 1'b0;
         wide_q <= 1'b0;
         hi_q <= 8'h00;
         lo_q <= 8'h00;
      end else if (accept) begin
         wr_q <= xmov_write_i;
         str_q <= aux_q[`CSA_AX_STRETCH];
         wide_q <= aux_q[`CSA_AX_WIDE];
         lo_q <= xmov_via_ptr_i ? ptr_lo_q[psel_q] : xmov_ri_addr_i;
         if (xmov_via_ptr_i && !aux_q[`CSA_AX_PHS]) begin
            hi_q <= ptr_hi_q[psel_q];
         end else begin
            hi_q <= port_latch_i;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         eram_q <= 1'b0;
         eram_addr_q <= 11'h000;
      end else begin
         eram_q <= accept && eram_hit;
         if (accept && eram_hit) begin
            eram_addr_q <= xmov_via_ptr_i ? data_pointer_o[10:0] : {3'b000, xmov_ri_addr_i};
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_q) begin
      if (!rst_b_q) begin
         div_q <= 2'd0;
      end else if (div_q == 2'(`CSA_ALE_DIV - 1)) begin
         div_q <= 2'd0;
      end else begin
         div_q <= div_q + 2'd1;
      end
   end

   assign ext_rd_b_o = !(state_q == csa_pkg::CSA_STRB && !wr_q);
   assign ext_wr_b_o = !(state_q == csa_pkg::CSA_STRB && wr_q);
   assign ale_o = (state_q == csa_pkg::CSA_ADDR) ||
      (state_q == csa_pkg::CSA_IDLE && !aux_q[`CSA_AX_QUIET] && div_q == 2'd0);
   assign high_addr_o = hi_q;
   assign low_addr_o = lo_q;
   assign wide_access_o = wide_q;
   assign eram_access_o = eram_q;
   assign eram_addr_o = eram_addr_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_q);

   a_odd_ones: assert property (program_status_o[0] == ^working_register_o)
      else $error("odd-ones flag mismatch");
   a_parity_load: assert property (work_we_i |=>
      program_status_o[0] == ^$past(work_wdata_i))
      else $error("parity not recomputed on load");
   a_carry_rec: assert property (alu_carry_we_i |=>
      program_status_o[7] == $past(alu_carry_i))
      else $error("carry not recorded");
   a_auxc_rec: assert property (alu_aux_carry_we_i |=>
      program_status_o[6] == $past(alu_aux_carry_i))
      else $error("aux carry not recorded");
   a_excess_rec: assert property (alu_excess_we_i |=>
      program_status_o[2] == $past(alu_excess_i))
      else $error("excess flag not recorded");
   a_user_hold: assert property (!wr_st |=> $stable(program_status_o[5]) &&
      $stable(program_status_o[1]))
      else $error("user flag changed without write");
   a_short_strobe: assert property ($fell(ext_rd_b_o & ext_wr_b_o) && !str_q |->
      !(ext_rd_b_o & ext_wr_b_o) [*3] ##1 (ext_rd_b_o & ext_wr_b_o))
      else $error("short strobe length wrong");
   a_long_strobe: assert property ($fell(ext_rd_b_o & ext_wr_b_o) && str_q |->
      !(ext_rd_b_o & ext_wr_b_o) [*8] ##1 !(ext_rd_b_o & ext_wr_b_o) [*7]
      ##1 (ext_rd_b_o & ext_wr_b_o))
      else $error("stretched strobe length wrong");
   a_ale_quiet: assert property (aux_q[0] && state_q != csa_pkg::CSA_ADDR |-> !ale_o)
      else $error("latch strobe outside move");
   a_ale_free: assert property (!aux_q[0] && !xmov_busy_o && !xmov_start_i && ale_o
      |=> !ale_o)
      else $error("free latch strobe too fast");
   a_high_suppress: assert property (accept && xmov_via_ptr_i && aux_q[4] |=>
      high_addr_o == $past(port_latch_i))
      else $error("pointer high byte not suppressed");
   a_far_external: assert property (accept && xmov_via_ptr_i &&
      data_pointer_o >= 16'h0800 |=> !eram_access_o ##1 state_q == csa_pkg::CSA_STRB)
      else $error("move above 0800h not external");
endmodule

// file: tb_top.sv
// Self-checking bench for the core status and auxiliary control block
`include "csa_cfg.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, work_wdata_i = 8'h00;
   logic [7:0] xmov_ri_addr_i = 8'h00, port_latch_i = 8'hc3;
   logic sfr_wr_i = 0, sfr_rd_i = 0, work_we_i = 0, xmov_start_i = 0;
   logic xmov_via_ptr_i = 0, xmov_write_i = 0;
   logic alu_carry_we_i = 0, alu_carry_i = 0, alu_aux_carry_we_i = 0, alu_aux_carry_i = 0;
   logic alu_excess_we_i = 0, alu_excess_i = 0;
   logic [7:0] sfr_rdata_o, program_status_o, working_register_o, high_addr_o, low_addr_o;
   logic [1:0] register_bank_select_o;
   logic [15:0] data_pointer_o;
   logic [10:0] eram_addr_o;
   logic xmov_busy_o, ext_rd_b_o, ext_wr_b_o, ale_o, wide_access_o, eram_access_o;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   csa_core_regs dut (.mclk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
      .sfr_rdata_o, .alu_carry_we_i, .alu_carry_i, .alu_aux_carry_we_i, .alu_aux_carry_i,
      .alu_excess_we_i, .alu_excess_i, .work_we_i, .work_wdata_i, .program_status_o,
      .working_register_o, .register_bank_select_o, .data_pointer_o, .xmov_start_i,
      .xmov_via_ptr_i, .xmov_write_i, .xmov_ri_addr_i, .port_latch_i, .xmov_busy_o,
      .ext_rd_b_o, .ext_wr_b_o, .ale_o, .high_addr_o, .low_addr_o, .wide_access_o,
      .eram_access_o, .eram_addr_o);

   ////////////////////////////////////////////////////////////////////////
   initial forever #25 mclk_i = ~mclk_i;

   // Whole run needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         $display("[ERR] run length expected below 6000 seen %0d", cycles);
         print_verdict();
      end
   end

   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1;
      @(posedge mclk_i);
      #1;
      sfr_wr_i = 0;
   endtask

   // Read data is registered, so it is looked at one cycle after the read edge
   task sfr_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge mclk_i);
      #1;
      sfr_addr_i = a;
      sfr_rd_i = 1;
      @(posedge mclk_i);
      #1;
      sfr_rd_i = 0;
      chk(nm, {8'h00, e}, {8'h00, sfr_rdata_o});
   endtask

   // Flag enables and values in the order carry, aux carry, excess
   task alu(input logic [2:0] we, input logic [2:0] v);
      @(posedge mclk_i);
      #1;
      {alu_carry_we_i, alu_aux_carry_we_i, alu_excess_we_i} = we;
      {alu_carry_i, alu_aux_carry_i, alu_excess_i} = v;
      @(posedge mclk_i);
      #1;
      {alu_carry_we_i, alu_aux_carry_we_i, alu_excess_we_i} = 3'b000;
   endtask

   task core_wr(input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      work_wdata_i = d;
      work_we_i = 1;
      @(posedge mclk_i);
      #1;
      work_we_i = 0;
   endtask

   task ale_count(input logic [7:0] e);
      logic [7:0] n;
      n = 8'h00;
      repeat (9) begin
         @(posedge mclk_i);
         #1;
         n = n + {7'h00, ale_o};
      end
      chk("latch strobe count", {8'h00, e}, {8'h00, n});
   endtask

   // Sets the controls and the pointer, runs one move, counts strobe cycles
   task move(input logic [7:0] aux, input logic [15:0] ptr, input logic via,
             input logic w, input logic [7:0] ri, input logic eram,
             input logic [15:0] a, input logic [7:0] cnt);
      logic [7:0] n;
      logic e, al;
      sfr_wr(`CSA_ADR_AUX, aux);
      sfr_wr(`CSA_ADR_PTR_HI, ptr[15:8]);
      sfr_wr(`CSA_ADR_PTR_LO, ptr[7:0]);
      @(posedge mclk_i);
      #1;
      xmov_via_ptr_i = via;
      xmov_write_i = w;
      xmov_ri_addr_i = ri;
      xmov_start_i = 1;
      @(posedge mclk_i);
      #1;
      xmov_start_i = 0;
      n = 8'h00;
      e = eram_access_o;
      al = ale_o;
      while (xmov_busy_o) begin
         @(posedge mclk_i);
         #1;
         if (w ? !ext_wr_b_o : !ext_rd_b_o)
            n = n + 8'h01;
      end
      chk("internal ram access", {15'h0000, eram}, {15'h0000, e});
      if (eram)
         chk("ram address", {5'h00, a[10:0]}, {5'h00, eram_addr_o});
      else begin
         chk("address", a, {high_addr_o, low_addr_o});
         chk("strobe cycles", {8'h00, cnt}, {8'h00, n});
         chk("latch strobe at address", 16'h0001, {15'h0000, al});
         chk("wide access", {15'h0000, aux[6]}, {15'h0000, wide_access_o});
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk_i);
      #1;
      rst_b_i = 1;
      repeat (3) @(posedge mclk_i);
      sfr_rd(`CSA_ADR_STATUS, 8'h00, "status reset");
      sfr_rd(`CSA_ADR_AUX, 8'h0d, "aux reset");
      sfr_rd(`CSA_ADR_STACK, 8'h07, "stack reset");
      ale_count(8'h00);
      sfr_wr(`CSA_ADR_AUX, 8'h7f);
      sfr_rd(`CSA_ADR_AUX, 8'h7f, "aux reserved bit");
      $display("test reset and reserved done");
      sfr_wr(`CSA_ADR_AUX2, 8'h00);
      sfr_wr(`CSA_ADR_PTR_HI, 8'h11);
      sfr_wr(`CSA_ADR_PTR_LO, 8'h11);
      sfr_wr(`CSA_ADR_AUX2, 8'h01);
      sfr_wr(`CSA_ADR_PTR_HI, 8'h22);
      sfr_wr(`CSA_ADR_PTR_LO, 8'h22);
      chk("pointer one", 16'h2222, data_pointer_o);
      sfr_wr(`CSA_ADR_AUX2, 8'h00);
      chk("pointer zero", 16'h1111, data_pointer_o);
      sfr_rd(`CSA_ADR_PTR_LO, 8'h11, "pointer low");
      $display("test pointer select done");
      sfr_wr(`CSA_ADR_WORK, 8'h00);
      alu(3'b111, 3'b111);
      chk("alu flags set", 16'h00c4, {8'h00, program_status_o});
      alu(3'b100, 3'b000);
      chk("carry cleared", 16'h0044, {8'h00, program_status_o});
      sfr_wr(`CSA_ADR_STATUS, 8'h3a);
      chk("user flags", 16'h003a, {8'h00, program_status_o});
      chk("bank select", 16'h0003, {14'h0000, register_bank_select_o});
      alu(3'b111, 3'b000);
      chk("user flags kept", 16'h003a, {8'h00, program_status_o});
      sfr_wr(`CSA_ADR_WORK, 8'h07);
      chk("odd parity", 16'h003b, {8'h00, program_status_o});
      core_wr(8'h03);
      chk("even parity", 16'h003a, {8'h00, program_status_o});
      chk("working register", 16'h0003, {8'h00, working_register_o});
      sfr_rd(`CSA_ADR_STATUS, 8'h3a, "status read");
      $display("test flags done");
      move(8'h00, 16'h0050, 1, 0, 8'h00, 1, 16'h0050, 8'h00);
      move(8'h00, 16'h0000, 0, 0, 8'h44, 1, 16'h0044, 8'h00);
      move(8'h00, 16'h0100, 1, 0, 8'h00, 0, 16'h0100, 8'h03);
      move(8'h0c, 16'h07ff, 1, 1, 8'h00, 1, 16'h07ff, 8'h00);
      move(8'h0c, 16'h0800, 1, 1, 8'h00, 0, 16'h0800, 8'h03);
      move(8'h71, 16'h0900, 1, 0, 8'h00, 0, 16'hc300, 8'h0f);
      move(8'h03, 16'h0000, 0, 1, 8'h5a, 0, 16'hc35a, 8'h03);
      $display("test moves done");
      ale_count(8'h00);
      sfr_wr(`CSA_ADR_AUX, 8'h00);
      ale_count(8'h03);
      $display("test latch strobe done");
      print_verdict();
   end
endmodule
